// ==== common/rzs_pkg.sv ====
// Shared constants, field layouts and carriers for the receive timeslot control block
//
// Overview of operation
// - Select codes 00/01/11 route D/E slot
// - Code 10 defers to separate source field
// - Only controller one takes data link bits
// - Twenty-four consecutive per-timeslot control registers
// - Type 00: octet passes untouched
// - Type 01: bit seven is stuffing
// - Type 10: bit eight, or seven conditionally
// - Type 11: octet replaced by 0x98
package rzs_pkg;

  // ----------------------------------------------------------------
  // Bus and address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SLOTS = 24;
  localparam logic [9:0] CHAN_CTRL_IDX_FIRST = 10'h0360;
  localparam logic [9:0] CHAN_CTRL_IDX_LAST = 10'h0377;
  localparam logic [9:0] SIG_LINK_SEL_IDX = 10'h010C;
  localparam logic [9:0] DE_SLOT_EN_IDX = 10'h03A0;
  localparam logic [9:0] ROUTE_STAT_IDX = 10'h03A1;
  localparam logic [9:0] ROUTE_CNT_IDX = 10'h03A2;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int ZS_HI = 5;
  localparam int ZS_LO = 4;
  localparam int COND_HI = 3;
  localparam int DE_SRC_HI = 1;
  localparam int DE_SRC_LO = 0;
  localparam logic [7:0] CHAN_CTRL_RESET = 8'h00;
  localparam logic [1:0] DE_SRC_RESET = 2'h0;
  localparam logic [23:0] DE_SLOT_EN_RESET = 24'h00_0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL1 = 2'h0;
  localparam logic [1:0] SEL_CTRL2 = 2'h1;
  localparam logic [1:0] SEL_DEFER = 2'h2;
  localparam logic [1:0] SEL_CTRL3 = 2'h3;
  localparam logic [1:0] DE_SRC_LINK = 2'h0;
  localparam logic [1:0] DE_SRC_CTRL1 = 2'h1;
  localparam logic [1:0] DE_SRC_CTRL2 = 2'h2;
  localparam logic [1:0] DE_SRC_CTRL3 = 2'h3;
  localparam logic [1:0] ZS_NONE = 2'h0;
  localparam logic [1:0] ZS_BIT7 = 2'h1;
  localparam logic [1:0] ZS_ALT = 2'h2;
  localparam logic [1:0] ZS_FILL = 2'h3;
  localparam logic [7:0] FILL_OCTET = 8'h98;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  // Line bit 1 is the octet MSB, so line bit 7 is index 1, bit 8 index 0
  localparam int LINE_BIT7 = 1;
  localparam int LINE_BIT8 = 0;
  localparam int NUM_CTRL = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] slot;
    logic [7:0] data;
    logic sig_frame;
    logic sig_bit;
  } rzs_octet_type;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] mask;
  } rzs_result_type;

endpackage

// ==== verilog/rzs_zero_suppress.sv ====
// Per-octet zero code suppression handling
`timescale 1ns/1ns
module rzs_zero_suppress
  import rzs_pkg::*;
(
  input wire rzs_octet_type octet,
  input wire logic [1:0] zs_type,
  output rzs_result_type result
);

  always_comb begin
    result.data = octet.data;
    result.mask = MASK_ALL;
    case (zs_type)
      ZS_NONE: begin
        result.mask = MASK_ALL;
      end
      ZS_BIT7: begin
        result.mask[LINE_BIT7] = 1'b0;
      end
      ZS_ALT: begin
        // Bit 8 is stuffed outside signaling frames; in them only a zero signaling bit forces bit 7
        if (!octet.sig_frame) begin
          result.mask[LINE_BIT8] = 1'b0;
        end else if (!octet.sig_bit) begin
          result.mask[LINE_BIT7] = 1'b0;
        end
      end
      ZS_FILL: begin
        result.data = FILL_OCTET;
      end
      default: begin
        result.mask = MASK_ALL;
      end
    endcase
  end

endmodule

// ==== verilog/rzs_hdlc_route.sv ====
// Choice of receive HDLC controller for one D/E octet
`timescale 1ns/1ns
module rzs_hdlc_route
  import rzs_pkg::*;
(
  input wire logic de_slot,
  input wire logic [1:0] slot_select,
  input wire logic [1:0] de_source,
  output logic [2:0] ctrl_onehot
);

  always_comb begin
    ctrl_onehot = 3'h0;
    if (de_slot) begin
      case (slot_select)
        SEL_CTRL1: ctrl_onehot = 3'h1;
        SEL_CTRL2: ctrl_onehot = 3'h2;
        SEL_CTRL3: ctrl_onehot = 3'h4;
        SEL_DEFER: begin
          // Link source code leaves the slot unused here
          case (de_source)
            DE_SRC_CTRL1: ctrl_onehot = 3'h1;
            DE_SRC_CTRL2: ctrl_onehot = 3'h2;
            DE_SRC_CTRL3: ctrl_onehot = 3'h4;
            default: ctrl_onehot = 3'h0;
          endcase
        end
        default: ctrl_onehot = 3'h0;
      endcase
    end
  end

endmodule

// ==== verilog/rzs_rx_channel.sv ====
// Receive timeslot control: registers, zero suppression and HDLC routing
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module rzs_rx_channel
  import rzs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_OCT_VALID,
  input wire rzs_octet_type RX_OCT,
  input wire logic RX_DL_VALID,
  input wire logic RX_DL_BIT,
  output logic RX_OUT_VALID,
  output logic [4:0] RX_OUT_SLOT,
  output rzs_result_type RX_OUT,
  output logic [2:0] HDLC_DE_VALID,
  output rzs_result_type HDLC_DE,
  output logic HDLC1_DL_VALID,
  output logic HDLC1_DL_BIT
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_CHAN = 3'b001,
    REG_SIGL = 3'b010,
    REG_DEEN = 3'b011,
    REG_STAT = 3'b100,
    REG_CNT = 3'b101
  } rzs_reg_type;

  function automatic rzs_reg_type decode_reg(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    decode_reg = REG_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx >= CHAN_CTRL_IDX_FIRST && idx <= CHAN_CTRL_IDX_LAST) begin
        decode_reg = REG_CHAN;
      end else if (idx == SIG_LINK_SEL_IDX) begin
        decode_reg = REG_SIGL;
      end else if (idx == DE_SLOT_EN_IDX) begin
        decode_reg = REG_DEEN;
      end else if (idx == ROUTE_STAT_IDX) begin
        decode_reg = REG_STAT;
      end else if (idx == ROUTE_CNT_IDX) begin
        decode_reg = REG_CNT;
      end
    end
  endfunction

  function automatic logic [4:0] decode_slot(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2] - CHAN_CTRL_IDX_FIRST;
    decode_slot = idx[4:0];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] chan_ctrl_r [NUM_SLOTS];
  logic [1:0] de_src_r;
  logic [23:0] de_slot_en_r;
  logic [7:0] route_cnt_r [NUM_CTRL];
  logic [4:0] last_slot_r;
  logic [2:0] last_ctrl_r;
  logic last_valid_r;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic acc_done;
  logic wr_done;
  rzs_reg_type acc_reg;
  logic [4:0] acc_slot;
  logic cnt_clear;
  logic [DATA_W-1:0] rd_nxt;

  logic [7:0] cfg_now;
  logic slot_ok;
  logic de_slot;
  rzs_result_type zs_res;
  logic [2:0] ctrl_sel;

  logic out_valid_r;
  logic [4:0] out_slot_r;
  rzs_result_type out_res_r;
  logic [2:0] de_valid_r;
  rzs_result_type de_res_r;
  logic dl_valid_r;
  logic dl_bit_r;

  // ----------------------------------------------------------------
  // APB slave, one wait state on every access
  // ----------------------------------------------------------------
  assign acc_reg = decode_reg(PADDR);
  assign acc_slot = decode_slot(PADDR);
  assign acc_done = PSEL && PENABLE && pready_r;
  assign wr_done = acc_done && PWRITE && (acc_reg != REG_NONE);
  assign cnt_clear = wr_done && (acc_reg == REG_CNT);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= PSEL && PENABLE && !pready_r;
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (acc_reg)
      REG_CHAN: rd_nxt[7:0] = chan_ctrl_r[acc_slot];
      REG_SIGL: rd_nxt[DE_SRC_HI:DE_SRC_LO] = de_src_r;
      REG_DEEN: rd_nxt[23:0] = de_slot_en_r;
      REG_STAT: rd_nxt[8:0] = {last_valid_r, last_ctrl_r, last_slot_r};
      REG_CNT: rd_nxt[23:0] = {route_cnt_r[2], route_cnt_r[1], route_cnt_r[0]};
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (PSEL && PENABLE && !pready_r) begin
      // Read data and error land together with PREADY
      prdata_r <= PWRITE ? '0 : rd_nxt;
      pslverr_r <= (acc_reg == REG_NONE) || (PWRITE && acc_reg == REG_STAT);
    end else begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // The datapath below reads the old value in a write's own cycle, so a
  // setting only ever changes between two occurrences of its slot
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_chan
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          chan_ctrl_r[gs] <= CHAN_CTRL_RESET;
        end else if (wr_done && acc_reg == REG_CHAN && acc_slot == 5'(gs)) begin
          chan_ctrl_r[gs] <= PWDATA[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      de_src_r <= DE_SRC_RESET;
    end else if (wr_done && acc_reg == REG_SIGL) begin
      de_src_r <= PWDATA[DE_SRC_HI:DE_SRC_LO];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      de_slot_en_r <= DE_SLOT_EN_RESET;
    end else if (wr_done && acc_reg == REG_DEEN) begin
      de_slot_en_r <= PWDATA[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-octet processing
  // ----------------------------------------------------------------
  // Slot numbers above 23 are dropped rather than aliased
  assign slot_ok = RX_OCT.slot < 5'(NUM_SLOTS);
  assign cfg_now = slot_ok ? chan_ctrl_r[RX_OCT.slot] : CHAN_CTRL_RESET;
  assign de_slot = RX_OCT_VALID && slot_ok && de_slot_en_r[RX_OCT.slot];

  rzs_zero_suppress u_zero_suppress (
    .octet(RX_OCT),
    .zs_type(cfg_now[ZS_HI:ZS_LO]),
    .result(zs_res)
  );

  rzs_hdlc_route u_hdlc_route (
    .de_slot(de_slot),
    .slot_select(cfg_now[SEL_HI:SEL_LO]),
    .de_source(de_src_r),
    .ctrl_onehot(ctrl_sel)
  );

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_valid_r <= 1'b0;
      out_slot_r <= '0;
      out_res_r <= '0;
    end else begin
      out_valid_r <= RX_OCT_VALID && slot_ok;
      if (RX_OCT_VALID && slot_ok) begin
        out_slot_r <= RX_OCT.slot;
        out_res_r <= zs_res;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      de_valid_r <= 3'h0;
      de_res_r <= '0;
    end else begin
      de_valid_r <= ctrl_sel;
      if (ctrl_sel != 3'h0) begin
        de_res_r <= zs_res;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data link bits, controller one only
  // ----------------------------------------------------------------
  // The link path is open only while the deferred source names the link
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dl_valid_r <= 1'b0;
      dl_bit_r <= 1'b0;
    end else begin
      dl_valid_r <= RX_DL_VALID && (de_src_r == DE_SRC_LINK);
      if (RX_DL_VALID) begin
        dl_bit_r <= RX_DL_BIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Routing status and counters
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_valid_r <= 1'b0;
      last_ctrl_r <= 3'h0;
      last_slot_r <= '0;
    end else if (ctrl_sel != 3'h0) begin
      last_valid_r <= 1'b1;
      last_ctrl_r <= ctrl_sel;
      last_slot_r <= RX_OCT.slot;
    end
  end

  // Counters saturate; a routed octet in the clearing cycle counts as one
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CTRL; gc++) begin : g_cnt
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          route_cnt_r[gc] <= 8'h00;
        end else if (cnt_clear) begin
          route_cnt_r[gc] <= {7'h00, ctrl_sel[gc]};
        end else if (ctrl_sel[gc] && route_cnt_r[gc] != 8'hFF) begin
          route_cnt_r[gc] <= route_cnt_r[gc] + 8'h01;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign RX_OUT_VALID = out_valid_r;
  assign RX_OUT_SLOT = out_slot_r;
  assign RX_OUT = out_res_r;
  assign HDLC_DE_VALID = de_valid_r;
  assign HDLC_DE = de_res_r;
  assign HDLC1_DL_VALID = dl_valid_r;
  assign HDLC1_DL_BIT = dl_bit_r;

endmodule

// ==== tb/rzs_rx_channel_sva.sv ====
// Port-level checks for the receive timeslot control block
`timescale 1ns/1ns
module rzs_rx_channel_sva
  import rzs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RX_OCT_VALID,
  input wire rzs_octet_type RX_OCT,
  input wire logic RX_DL_VALID,
  input wire logic RX_DL_BIT,
  input wire logic RX_OUT_VALID,
  input wire logic [4:0] RX_OUT_SLOT,
  input wire rzs_result_type RX_OUT,
  input wire logic [2:0] HDLC_DE_VALID,
  input wire rzs_result_type HDLC_DE,
  input wire logic HDLC1_DL_VALID,
  input wire logic HDLC1_DL_BIT
);
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_one_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == '0 && !PSLVERR)
    else $error("read data outside answer");
  out_latency_a: assert property (RX_OCT_VALID && RX_OCT.slot < 5'd24 |=>
    RX_OUT_VALID && RX_OUT_SLOT == $past(RX_OCT.slot)) else $error("octet output late");
  out_drop_a: assert property (!(RX_OCT_VALID && RX_OCT.slot < 5'd24) |=> !RX_OUT_VALID)
    else $error("spurious octet output");
  de_onehot_a: assert property ($onehot0(HDLC_DE_VALID))
    else $error("several controllers chosen");
  de_match_a: assert property (|HDLC_DE_VALID |-> RX_OUT_VALID && HDLC_DE == RX_OUT)
    else $error("routed octet differs");
  dl_path_a: assert property (HDLC1_DL_VALID |-> $past(RX_DL_VALID)
    && HDLC1_DL_BIT == $past(RX_DL_BIT)) else $error("link bit wrong");
  mask_code_a: assert property (RX_OUT_VALID |-> RX_OUT.mask inside {8'hFF, 8'hFD, 8'hFE})
    else $error("bad stuffing mask");
endmodule

bind rzs_rx_channel rzs_rx_channel_sva chk (
  .REF_CLK(REF_CLK),
  .RESET_N(RESET_N),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .RX_OCT_VALID(RX_OCT_VALID),
  .RX_OCT(RX_OCT),
  .RX_DL_VALID(RX_DL_VALID),
  .RX_DL_BIT(RX_DL_BIT),
  .RX_OUT_VALID(RX_OUT_VALID),
  .RX_OUT_SLOT(RX_OUT_SLOT),
  .RX_OUT(RX_OUT),
  .HDLC_DE_VALID(HDLC_DE_VALID),
  .HDLC_DE(HDLC_DE),
  .HDLC1_DL_VALID(HDLC1_DL_VALID),
  .HDLC1_DL_BIT(HDLC1_DL_BIT)
);

// ==== tb/rzs_line_model.sv ====
// Incoming line model: octets and data link bits
`timescale 1ns/1ns
module rzs_line_model
  import rzs_pkg::*;
(
  input wire logic clk,
  output logic oct_valid,
  output rzs_octet_type oct,
  output logic dl_valid,
  output logic dl_bit
);
  initial begin
    oct_valid = 1'b0;
    oct = '0;
    dl_valid = 1'b0;
    dl_bit = 1'b0;
  end

  // Idle lines carry the inverse so a stale octet is never taken as new
  task automatic send_oct(input rzs_octet_type o);
    @(posedge clk);
    oct_valid <= 1'b1;
    oct <= o;
    @(posedge clk);
    oct_valid <= 1'b0;
    oct <= ~o;
  endtask

  task automatic send_dl(input logic b);
    @(posedge clk);
    dl_valid <= 1'b1;
    dl_bit <= b;
    @(posedge clk);
    dl_valid <= 1'b0;
    dl_bit <= ~b;
  endtask
endmodule

// ==== tb/rzs_rx_channel_tb_top.sv ====
// Self-checking bench for the receive timeslot control block
`timescale 1ns/1ns
module rzs_rx_channel_tb_top
  import rzs_pkg::*;
();
  logic REF_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [ADDR_W-1:0] PADDR;
  logic [DATA_W-1:0] PWDATA, PRDATA, rd_v;
  logic RX_OCT_VALID, RX_DL_VALID, RX_DL_BIT, RX_OUT_VALID, HDLC1_DL_VALID, HDLC1_DL_BIT;
  logic err_v;
  rzs_octet_type RX_OCT;
  logic [4:0] RX_OUT_SLOT;
  rzs_result_type RX_OUT, HDLC_DE;
  logic [2:0] HDLC_DE_VALID;
  int n_fail, total_checks, cyc;

  rzs_rx_channel uut (
    .REF_CLK(REF_CLK),
    .RESET_N(RESET_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .RX_OCT_VALID(RX_OCT_VALID),
    .RX_OCT(RX_OCT),
    .RX_DL_VALID(RX_DL_VALID),
    .RX_DL_BIT(RX_DL_BIT),
    .RX_OUT_VALID(RX_OUT_VALID),
    .RX_OUT_SLOT(RX_OUT_SLOT),
    .RX_OUT(RX_OUT),
    .HDLC_DE_VALID(HDLC_DE_VALID),
    .HDLC_DE(HDLC_DE),
    .HDLC1_DL_VALID(HDLC1_DL_VALID),
    .HDLC1_DL_BIT(HDLC1_DL_BIT)
  );
  rzs_line_model line (.clk(REF_CLK), .oct_valid(RX_OCT_VALID), .oct(RX_OCT),
    .dl_valid(RX_DL_VALID), .dl_bit(RX_DL_BIT));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Only the bench watchdog ends a wait that never sees ready
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd_v = PRDATA;
    err_v = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    chk("write_err", 32'(err_v), 32'h0000_0000);
  endtask

  // Sends one octet and compares the routed result one cycle later
  task automatic oct_chk(input logic [4:0] s, input logic [7:0] d, input logic sf,
    input logic sb, input logic [15:0] exp, input logic [2:0] de);
    line.send_oct({s, d, sf, sb});
    #1;
    chk("out_valid", 32'(RX_OUT_VALID), 32'h0000_0001);
    chk("out_slot", 32'(RX_OUT_SLOT), 32'(s));
    if (de != 3'h0) chk("de_data_mask", 32'(HDLC_DE), 32'(exp));
    chk("out_data_mask", 32'(RX_OUT), 32'(exp));
    chk("de_valid", 32'(HDLC_DE_VALID), 32'(de));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_regs();
    apb(1'b0, 12'hD80, 32'h0000_0000);
    chk("ts0_reset", rd_v, 32'h0000_0000);
    wreg(12'hD80, 32'hFFFF_FFA5);
    wreg(12'hDDC, 32'h0000_005A);
    apb(1'b0, 12'hD80, 32'h0000_0000);
    chk("ts0_read", rd_v, 32'h0000_00A5);
    apb(1'b0, 12'hDDC, 32'h0000_0000);
    chk("ts23_read", rd_v, 32'h0000_005A);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("unmapped_err", 32'(err_v), 32'h0000_0001);
    chk("unmapped_read", rd_v, 32'h0000_0000);
  endtask

  task automatic s_zs();
    logic [1:0] zs[6] = '{ZS_NONE, ZS_BIT7, ZS_ALT, ZS_ALT, ZS_ALT, ZS_FILL};
    logic [5:0] sf = 6'b011000;
    logic [5:0] sb = 6'b010000;
    logic [7:0] mk[6] = '{8'hFF, 8'hFD, 8'hFE, 8'hFD, 8'hFF, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      wreg(12'hD94, 32'({SEL_CTRL1, zs[i], 4'h0}));
      oct_chk(5'd5, 8'h00, sf[i], sb[i], {(i == 5) ? 8'h98 : 8'h00, mk[i]}, 3'h0);
    end
    // Octet taken at the very edge of the write still sees the old setting
    fork
      wreg(12'hD94, 32'({SEL_CTRL1, ZS_NONE, 4'h0}));
      begin
        repeat (2) @(posedge REF_CLK);
        line.send_oct({5'd5, 8'h00, 1'b0, 1'b0});
      end
    join
    #1;
    chk("old_setting", 32'(RX_OUT), 32'h0000_98FF);
    oct_chk(5'd5, 8'h00, 1'b0, 1'b0, 16'h00FF, 3'h0);
  endtask

  task automatic s_route();
    logic [1:0] sel[7] = '{SEL_CTRL1, SEL_CTRL2, SEL_CTRL3, SEL_DEFER, SEL_DEFER, SEL_DEFER,
      SEL_DEFER};
    logic [1:0] src[7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [2:0] de[7] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4, 3'h0};
    wreg(12'hE80, 32'h0000_0008);
    for (int i = 0; i < 7; i++) begin
      wreg(12'h430, 32'(src[i]));
      wreg(12'hD8C, 32'({sel[i], ZS_NONE, 4'h0}));
      oct_chk(5'd3, 8'h3C, 1'b0, 1'b0, 16'h3CFF, de[i]);
    end
    line.send_oct({5'd24, 8'h11, 1'b0, 1'b0});
    #1;
    chk("slot24_drop", 32'(RX_OUT_VALID), 32'h0000_0000);
    apb(1'b0, 12'hE84, 32'h0000_0000);
    chk("route_status", rd_v, 32'h0000_0183);
    apb(1'b0, 12'hE88, 32'h0000_0000);
    chk("route_counts", rd_v, 32'h0002_0202);
    wreg(12'hE88, 32'h0000_0000);
    apb(1'b0, 12'hE88, 32'h0000_0000);
    chk("counts_cleared", rd_v, 32'h0000_0000);
    apb(1'b1, 12'hE84, 32'h0000_0000);
    chk("status_wr_err", 32'(err_v), 32'h0000_0001);
  endtask

  task automatic s_dl();
    for (int i = 0; i < 3; i++) begin
      wreg(12'h430, 32'((i == 2) ? 2'h1 : 2'h0));
      line.send_dl(i[0]);
      #1;
      chk("dl_valid", 32'(HDLC1_DL_VALID), 32'((i == 2) ? 1'b0 : 1'b1));
      if (i < 2) chk("dl_bit", 32'(HDLC1_DL_BIT), 32'(i[0]));
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // Bound chosen well above the few hundred cycles of traffic
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    repeat (10) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    s_regs();
    s_zs();
    s_route();
    s_dl();
    final_report();
  end
endmodule
